/* File: rtl/fpu_cc_encode.sv */
// Next condition-code value for one accepted command.
// Assumes the datapath supplies compare, class, quotient and rounding outcomes.
`timescale 1ns/1ps
`include "fpu_status_defines.svh"
module fpu_cc_encode (
	input  wire fpu_status_pkg::cmd_s  i_cmd,
	input  wire logic [15:0]           i_load_status,
	input  wire logic [3:0]            i_cc,
	output logic [3:0]                 o_cc
);
	// Bit order of o_cc: [3]=C3, [2]=C2, [1]=C1, [0]=C0.
	logic       c1_arith;
	logic [2:0] cmp_code;

	always_comb begin
		c1_arith = i_cmd.stack_fault ? i_cmd.stack_over : i_cmd.roundup;
		unique case (i_cmd.cmp)
			fpu_status_pkg::CMP_GREATER: cmp_code = `CMP_CODE_GREATER;
			fpu_status_pkg::CMP_LESS:    cmp_code = `CMP_CODE_LESS;
			fpu_status_pkg::CMP_EQUAL:   cmp_code = `CMP_CODE_EQUAL;
			fpu_status_pkg::CMP_UNORD:   cmp_code = `CMP_CODE_UNORD;
		endcase
		o_cc = i_cc;
		unique case (i_cmd.op)
			fpu_status_pkg::OP_PREM: begin
				if (i_cmd.incomplete) begin
					o_cc = `CC_INCOMPLETE;
				end else begin
					o_cc = {i_cmd.quotient[1], 1'b0,
						i_cmd.stack_fault ? i_cmd.stack_over : i_cmd.quotient[0],
						i_cmd.quotient[2]};
				end
			end
			fpu_status_pkg::OP_COMPARE: begin
				o_cc = {cmp_code[2], cmp_code[1],
					i_cmd.stack_fault & i_cmd.stack_over, cmp_code[0]};
			end
			fpu_status_pkg::OP_EXAMINE: begin
				o_cc = {i_cmd.cls[2], i_cmd.cls[1], i_cmd.sign, i_cmd.cls[0]};
			end
			fpu_status_pkg::OP_TRIG: begin
				o_cc[2] = i_cmd.out_of_range;
				o_cc[1] = c1_arith;
			end
			fpu_status_pkg::OP_ARITH: begin
				o_cc[1] = c1_arith;
			end
			fpu_status_pkg::OP_LOAD_ENV,
			fpu_status_pkg::OP_RESTORE: begin
				o_cc = {i_load_status[`SW_C3], i_load_status[`SW_C2],
					i_load_status[`SW_C1], i_load_status[`SW_C0]};
			end
			default: begin
				o_cc = i_cc;
			end
		endcase
	end
endmodule // fpu_cc_encode

/* File: rtl/fpu_pointer_store.sv */
// Instruction and data pointer storage for exception handlers, with registered read data.
// Assumes one write port driven by the control unit on the same clock.
`timescale 1ns/1ps
module fpu_pointer_store (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_wr_en,
	input  wire logic                  i_keep_data_addr,
	input  wire fpu_status_pkg::ptr_s  i_wr,
	output fpu_status_pkg::ptr_s       o_rd
);
	fpu_status_pkg::ptr_state_s s_r;
	fpu_status_pkg::ptr_state_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (i_wr_en) begin
			s_nxt.mem.instr_addr = i_wr.instr_addr;
			s_nxt.mem.opcode     = i_wr.opcode;
			// The data pointer is left as it was when the escape has no memory operand.
			if (!i_keep_data_addr) begin
				s_nxt.mem.data_addr = i_wr.data_addr;
			end
		end
		// Write-through so a store right after a capture sees the new pointers.
		s_nxt.rd = s_nxt.mem;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_rd = s_r.rd;
endmodule // fpu_pointer_store

/* File: rtl/fpu_status_control_exceptions.sv */
// Status, control and tag words of the numeric coprocessor, with error reporting.
// Assumes the datapath and the escape decoder drive I_CMD on I_REF_CLK, one command per cycle.
// Assumes I_LOAD_IMAGE is settled in the cycle of a load command; it is ignored otherwise.
`timescale 1ns/1ps
`include "fpu_status_defines.svh"
module fpu_status_control_exceptions (
	input  wire logic                  I_REF_CLK,
	input  wire logic                  I_NRST,
	input  wire fpu_status_pkg::cmd_s  I_CMD,
	input  wire fpu_status_pkg::env_s  I_LOAD_IMAGE,
	output logic                       O_TRAP_REQ,
	output logic                       O_ERROR,
	output logic [15:0]                O_STATUS_WORD,
	output logic [15:0]                O_CONTROL_WORD,
	output logic [15:0]                O_TAG_WORD,
	output logic [1:0]                 O_ROUNDING_SELECT,
	output logic [1:0]                 O_PRECISION_SELECT,
	output logic [5:0]                 O_EXC_MASK,
	output logic [5:0]                 O_DEFAULT_ACTION,
	output logic [5:0]                 O_FIRST_UNMASKED,
	output logic                       O_KEEP_OPERAND,
	output fpu_status_pkg::env_s       O_STORE_IMAGE,
	output logic                       O_STORE_VALID
);
	fpu_status_pkg::ctl_state_s s_r;
	fpu_status_pkg::ctl_state_s s_nxt;
	fpu_status_pkg::ptr_s       ptr_rd;
	fpu_status_pkg::ptr_s       ptr_wr;
	logic [3:0]                 cc_enc;
	logic                       accept;
	logic                       ptr_we;
	logic                       ptr_keep_dp;
	logic                       no_trap_op;
	logic [`NUM_DATA_REGS-1:0]  tag_hit;

	// Flag order is invalid, denormal, zero divide, overflow, underflow, precision,
	// which is also the precedence; lowest index wins.
	function automatic logic [5:0] first_set(input logic [5:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 5; i >= 0; i--) begin
			if (v[i]) begin
				r = 6'h01 << i;
			end
		end
		return r;
	endfunction

	// A flag counts toward the error only while its mask bit is clear.
	function automatic logic summary_of(input logic [5:0] flags, input logic [15:0] cw);
		return |(flags & ~cw[`CW_MASK_HI:`CW_MASK_LO]);
	endfunction

	// Bit 15 is a copy of the summary, never a register of its own, so the two cannot part.
	function automatic logic [15:0] status_of(input fpu_status_pkg::ctl_state_s st);
		logic [15:0] w;
		w = 16'h0000;
		w[`SW_BUSY_MIRROR]                  = st.summary;
		w[`SW_C3]                           = st.cc[3];
		w[`SW_TOP_HI:`SW_TOP_LO]            = st.top;
		w[`SW_C2]                           = st.cc[2];
		w[`SW_C1]                           = st.cc[1];
		w[`SW_C0]                           = st.cc[0];
		w[`SW_ERROR_SUMMARY]                = st.summary;
		w[`SW_STACK_FAULT]                  = st.stack_fault;
		w[`SW_FLAGS_HI:`SW_FLAGS_LO]        = st.flags;
		return w;
	endfunction

	function automatic logic is_control_op(input fpu_status_pkg::op_e op);
		return op inside {fpu_status_pkg::OP_LOAD_ENV, fpu_status_pkg::OP_RESTORE,
			fpu_status_pkg::OP_STORE_ENV, fpu_status_pkg::OP_SAVE,
			fpu_status_pkg::OP_INIT, fpu_status_pkg::OP_CLEAR,
			fpu_status_pkg::OP_STORE_SW, fpu_status_pkg::OP_LOAD_CW,
			fpu_status_pkg::OP_STORE_CW};
	endfunction

	function automatic logic is_reload_op(input fpu_status_pkg::op_e op);
		return op inside {fpu_status_pkg::OP_LOAD_ENV, fpu_status_pkg::OP_RESTORE};
	endfunction

	// No-wait forms exempt.
	// Without them a handler could never inspect or clear a pending error.
	always_comb begin
		no_trap_op = I_CMD.nowait & (I_CMD.op inside {fpu_status_pkg::OP_INIT,
			fpu_status_pkg::OP_CLEAR, fpu_status_pkg::OP_STORE_SW,
			fpu_status_pkg::OP_STORE_ENV, fpu_status_pkg::OP_SAVE});
	end

	// Trap request on escape.
	// A trapped escape is refused here, so it can be restarted after the handler.
	// Refusing also leaves the pointers alone, so the handler still sees the faulting
	// escape and not the one that tripped over the pending error.
	assign O_TRAP_REQ = I_CMD.valid & s_r.summary & ~no_trap_op;
	// One command per edge; a refused one is simply not taken and the host retries it.
	assign accept     = I_CMD.valid & ~O_TRAP_REQ;

	// Condition bits are worked out beside the state so each encoding sits in one place.
	fpu_cc_encode u_cc_encode (
		.i_cmd         (I_CMD),
		.i_load_status (I_LOAD_IMAGE.status),
		.i_cc          (s_r.cc),
		.o_cc          (cc_enc)
	);

	// Data pointer kept without operand.
	// Control operations other than the two reloads leave the pointers alone: a handler that stores the environment
	// must see the escape that failed, not the store itself.
	always_comb begin
		ptr_we      = 1'b0;
		ptr_keep_dp = 1'b0;
		ptr_wr      = I_CMD.ptr;
		if (accept) begin
			if (is_reload_op(I_CMD.op)) begin
				ptr_we = 1'b1;
				ptr_wr = I_LOAD_IMAGE.ptr;
			end else if (!is_control_op(I_CMD.op)) begin
				ptr_we      = 1'b1;
				ptr_keep_dp = ~I_CMD.has_mem;
			end
		end
	end

	fpu_pointer_store u_pointer_store (
		.i_clk            (I_REF_CLK),
		.i_rst_n          (I_NRST),
		.i_wr_en          (ptr_we),
		.i_keep_data_addr (ptr_keep_dp),
		.i_wr             (ptr_wr),
		.o_rd             (ptr_rd)
	);

	// Tag write strobes.
	// Each strobe matches an absolute register number; the stack top never enters the
	// index, so a push or pop in the same command cannot move the tag that is written.
	for (genvar g = 0; g < `NUM_DATA_REGS; g++) begin : g_tag_hit
		assign tag_hit[g] = I_CMD.tag_we & (I_CMD.tag_idx == 3'(g));
	end

	always_comb begin
		s_nxt                = s_r;
		s_nxt.store_valid    = 1'b0;
		s_nxt.default_action = 6'h00;
		s_nxt.first_unmasked = 6'h00;
		s_nxt.keep_operand   = 1'b0;
		if (accept) begin
			unique case (I_CMD.op)
				// Infinity bit cleared.
				// Initialize also clears the condition bits, which are otherwise undefined.
				fpu_status_pkg::OP_INIT: begin
					s_nxt.control     = `CW_RESET_VALUE;
					s_nxt.flags       = `FLAGS_CLEAR;
					s_nxt.stack_fault = 1'b0;
					s_nxt.top         = `TOP_RESET_VALUE;
					s_nxt.tags        = `TW_RESET_VALUE;
					s_nxt.cc          = `CC_CLEAR;
				end
				fpu_status_pkg::OP_CLEAR: begin
					s_nxt.flags       = `FLAGS_CLEAR;
					s_nxt.stack_fault = 1'b0;
				end
				// Infinity bit stored.
				// Only the control word moves; the error may still change with the new masks.
				fpu_status_pkg::OP_LOAD_CW: begin
					s_nxt.control = I_LOAD_IMAGE.control;
				end
				fpu_status_pkg::OP_LOAD_ENV,
				fpu_status_pkg::OP_RESTORE: begin
					s_nxt.control     = I_LOAD_IMAGE.control;
					s_nxt.flags       = I_LOAD_IMAGE.status[`SW_FLAGS_HI:`SW_FLAGS_LO];
					s_nxt.stack_fault = I_LOAD_IMAGE.status[`SW_STACK_FAULT];
					s_nxt.top         = I_LOAD_IMAGE.status[`SW_TOP_HI:`SW_TOP_LO];
					s_nxt.tags        = I_LOAD_IMAGE.tags;
					s_nxt.cc          = cc_enc;
				end
				// Environment store.
				// Condition bits are not touched, which satisfies the undefined case.
				// The image is the state before this command, so a store never sees itself.
				fpu_status_pkg::OP_STORE_ENV,
				fpu_status_pkg::OP_SAVE,
				fpu_status_pkg::OP_STORE_SW,
				fpu_status_pkg::OP_STORE_CW: begin
					s_nxt.store_image.control = s_r.control;
					s_nxt.store_image.status  = status_of(s_r);
					s_nxt.store_image.tags    = s_r.tags;
					s_nxt.store_image.ptr     = ptr_rd;
					s_nxt.store_valid         = 1'b1;
				end
				// Every command that executes on the datapath lands here.
				fpu_status_pkg::OP_NOP,
				fpu_status_pkg::OP_ARITH,
				fpu_status_pkg::OP_PREM,
				fpu_status_pkg::OP_COMPARE,
				fpu_status_pkg::OP_EXAMINE,
				fpu_status_pkg::OP_TRIG: begin
					s_nxt.flags = s_r.flags | I_CMD.exc;
					if (I_CMD.stack_fault) begin
						s_nxt.stack_fault = 1'b1;
					end
					s_nxt.cc = cc_enc;
					s_nxt.default_action = I_CMD.exc & s_r.control[`CW_MASK_HI:`CW_MASK_LO];
					s_nxt.first_unmasked = first_set(I_CMD.exc &
						~s_r.control[`CW_MASK_HI:`CW_MASK_LO]);
					s_nxt.keep_operand = (I_CMD.op == fpu_status_pkg::OP_TRIG) &
						I_CMD.out_of_range;
					if (I_CMD.push && !I_CMD.pop) begin
						s_nxt.top = s_r.top - 3'h1;
					end else if (I_CMD.pop && !I_CMD.push) begin
						s_nxt.top = s_r.top + 3'h1;
					end
					for (int i = 0; i < `NUM_DATA_REGS; i++) begin
						if (tag_hit[i]) begin
							s_nxt.tags[i * `TAG_BITS +: `TAG_BITS] = I_CMD.tag_code;
						end
					end
				end
				// The spare op code changes no flag, condition bit, tag or stack top; only the pointers record it, as for arithmetic.
				default: begin
				end
			endcase
		end
		// Recomputed after every change, so a reload raises the error at once.
		// Working from the next flags and masks keeps the error pin in step with the flags;
		// a copy of the old state would let one more escape slip through unrefused.
		s_nxt.summary = summary_of(s_nxt.flags, s_nxt.control);
	end

	// Synchronous reset only: every output but O_TRAP_REQ settles on a clock edge, the first one too.
	always_ff @(posedge I_REF_CLK) begin
		if (!I_NRST) begin
			// Reset tags empty.
			// Pulses, flags and the stack-top index start at zero by the same clear.
			s_r         <= '0;
			s_r.control <= `CW_RESET_VALUE;
			s_r.tags    <= `TW_RESET_VALUE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Every output below is a straight copy of state, so none of them can glitch.
	// Error output from summary.
	assign O_ERROR            = s_r.summary;
	assign O_STATUS_WORD      = status_of(s_r);
	assign O_CONTROL_WORD     = s_r.control;
	assign O_TAG_WORD         = s_r.tags;
	assign O_ROUNDING_SELECT  = s_r.control[`CW_ROUND_HI:`CW_ROUND_LO];
	assign O_PRECISION_SELECT = s_r.control[`CW_PREC_HI:`CW_PREC_LO];
	assign O_EXC_MASK         = s_r.control[`CW_MASK_HI:`CW_MASK_LO];
	assign O_DEFAULT_ACTION   = s_r.default_action;
	assign O_FIRST_UNMASKED   = s_r.first_unmasked;
	assign O_KEEP_OPERAND     = s_r.keep_operand;
	assign O_STORE_IMAGE      = s_r.store_image;
	assign O_STORE_VALID      = s_r.store_valid;
endmodule // fpu_status_control_exceptions

/* File: rtl/fpu_status_defines.svh */
// Bit positions, reset values and field codes of the numeric control, status and tag words.
// Assumes inclusion by bare name from design files that need these constants.
`ifndef FPU_STATUS_DEFINES_SVH
`define FPU_STATUS_DEFINES_SVH

`define SW_BUSY_MIRROR   15
`define SW_C3            14
`define SW_TOP_HI        13
`define SW_TOP_LO        11
`define SW_C2            10
`define SW_C1            9
`define SW_C0            8
`define SW_ERROR_SUMMARY 7
`define SW_STACK_FAULT   6
`define SW_FLAGS_HI      5
`define SW_FLAGS_LO      0

`define CW_INFINITY_CTL  12
`define CW_ROUND_HI      11
`define CW_ROUND_LO      10
`define CW_PREC_HI       9
`define CW_PREC_LO       8
`define CW_MASK_HI       5
`define CW_MASK_LO       0

`define CW_RESET_VALUE   16'h037f
`define TW_RESET_VALUE   16'hffff
`define TOP_RESET_VALUE  3'h0
`define FLAGS_CLEAR      6'h00
`define CC_CLEAR         4'h0
`define CC_INCOMPLETE    4'h4
`define NUM_DATA_REGS    8
`define TAG_BITS         2

`define TAG_CODE_VALID   2'h0
`define TAG_CODE_ZERO    2'h1
`define TAG_CODE_EMPTY   2'h3

`define CMP_CODE_GREATER 3'h0
`define CMP_CODE_LESS    3'h1
`define CMP_CODE_EQUAL   3'h4
`define CMP_CODE_UNORD   3'h7

`endif

/* File: rtl/fpu_status_pkg.sv */
// Types shared by the numeric status, control and exception logic.
// Assumes the datapath and bus unit on the same clock produce the command fields.
package fpu_status_pkg;

	typedef enum logic [3:0] {
		OP_NOP       = 4'h0,
		OP_ARITH     = 4'h1,
		OP_PREM      = 4'h2,
		OP_COMPARE   = 4'h3,
		OP_EXAMINE   = 4'h4,
		OP_TRIG      = 4'h5,
		OP_LOAD_ENV  = 4'h6,
		OP_RESTORE   = 4'h7,
		OP_STORE_ENV = 4'h8,
		OP_SAVE      = 4'h9,
		OP_INIT      = 4'ha,
		OP_CLEAR     = 4'hb,
		OP_STORE_SW  = 4'hc,
		OP_LOAD_CW   = 4'hd,
		OP_STORE_CW  = 4'he
	} op_e;

	typedef enum logic [1:0] {
		CMP_GREATER = 2'h0,
		CMP_LESS    = 2'h1,
		CMP_EQUAL   = 2'h2,
		CMP_UNORD   = 2'h3
	} cmp_e;

	// Codes are the C3, C2, C0 pattern of the examine result.
	typedef enum logic [2:0] {
		CLS_UNSUPPORTED = 3'h0,
		CLS_NAN         = 3'h1,
		CLS_NORMAL      = 3'h2,
		CLS_INFINITY    = 3'h3,
		CLS_ZERO        = 3'h4,
		CLS_EMPTY       = 3'h5,
		CLS_DENORMAL    = 3'h6
	} class_e;

	typedef struct packed {
		logic [19:0] instr_addr;
		logic [19:0] data_addr;
		logic [10:0] opcode;
	} ptr_s;

	typedef struct packed {
		logic [15:0] control;
		logic [15:0] status;
		logic [15:0] tags;
		ptr_s        ptr;
	} env_s;

	typedef struct packed {
		logic        valid;
		op_e         op;
		logic        nowait;
		logic        push;
		logic        pop;
		logic [5:0]  exc;
		logic        stack_fault;
		logic        stack_over;
		logic        roundup;
		cmp_e        cmp;
		class_e      cls;
		logic        sign;
		logic [2:0]  quotient;
		logic        incomplete;
		logic        out_of_range;
		logic        has_mem;
		logic        tag_we;
		logic [2:0]  tag_idx;
		logic [1:0]  tag_code;
		ptr_s        ptr;
	} cmd_s;

	typedef struct packed {
		logic [15:0] control;
		logic [5:0]  flags;
		logic        stack_fault;
		logic [3:0]  cc;
		logic [2:0]  top;
		logic [15:0] tags;
		logic        summary;
		logic [5:0]  default_action;
		logic [5:0]  first_unmasked;
		logic        keep_operand;
		env_s        store_image;
		logic        store_valid;
	} ctl_state_s;

	typedef struct packed {
		ptr_s mem;
		ptr_s rd;
	} ptr_state_s;

endpackage

/* File: testbench/fpu_host_model.sv */
// Host model that issues escape instructions and takes the numeric error vector.
// Assumes the bench calls issue() and wires the unit's clock and trap request here.
`timescale 1ns/1ps
module fpu_host_model (
	input  wire logic             i_clk,
	input  wire logic             i_trap,
	output fpu_status_pkg::cmd_s  o_cmd,
	output fpu_status_pkg::env_s  o_image
);
	localparam int ERR_VECTOR = 16;
	int vector_taken;
	initial begin
		o_cmd = '0;
		o_image = '0;
		vector_taken = 0;
	end
	task automatic issue(input fpu_status_pkg::cmd_s c, input fpu_status_pkg::env_s e,
		output logic trapped);
		@(posedge i_clk);
		o_cmd <= c;
		o_image <= e;
		#1;
		trapped = i_trap;
		vector_taken = (trapped === 1'b1) ? ERR_VECTOR : 0;
		@(posedge i_clk);
		o_cmd.valid <= 1'b0;
		// The memory image is not held once read, so stale data cannot pass for a load.
		o_image <= ~e;
		#1;
	endtask
endmodule // fpu_host_model

/* File: testbench/fpu_status_assertions.sv */
// Concurrent checks on the ports of the numeric status and control unit.
// Assumes one clock domain and the synchronous active-low reset of the unit.
`timescale 1ns/1ps
module fpu_status_assertions (
	input  wire logic                  I_REF_CLK,
	input  wire logic                  I_NRST,
	input  wire fpu_status_pkg::cmd_s  I_CMD,
	input  wire logic                  O_TRAP_REQ,
	input  wire logic                  O_ERROR,
	input  wire logic [15:0]           O_STATUS_WORD,
	input  wire logic [15:0]           O_CONTROL_WORD,
	input  wire logic [15:0]           O_TAG_WORD,
	input  wire logic [1:0]            O_ROUNDING_SELECT,
	input  wire logic [1:0]            O_PRECISION_SELECT,
	input  wire logic [5:0]            O_EXC_MASK,
	input  wire logic                  O_KEEP_OPERAND,
	input  wire logic                  O_STORE_VALID
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);
	logic exempt;
	assign exempt = I_CMD.nowait && (I_CMD.op inside {fpu_status_pkg::OP_INIT,
		fpu_status_pkg::OP_CLEAR, fpu_status_pkg::OP_STORE_SW,
		fpu_status_pkg::OP_STORE_ENV, fpu_status_pkg::OP_SAVE});
	function automatic logic [2:0] cmp_map(fpu_status_pkg::cmp_e k);
		return (k == fpu_status_pkg::CMP_GREATER) ? 3'h0 : (k == fpu_status_pkg::CMP_LESS) ? 3'h1
			: (k == fpu_status_pkg::CMP_EQUAL) ? 3'h4 : 3'h7;
	endfunction
	sequence s_take(fpu_status_pkg::op_e o);
		I_CMD.valid && !O_TRAP_REQ && I_CMD.op == o;
	endsequence
	a_busy_mirror: assert property (O_STATUS_WORD[15] == O_STATUS_WORD[7])
		else $error("busy mirror differs from summary");
	a_error_summary: assert property (O_ERROR == O_STATUS_WORD[7] &&
		O_ERROR == |(O_STATUS_WORD[5:0] & ~O_EXC_MASK)) else $error("summary or error wrong");
	a_mode_fields: assert property ({O_ROUNDING_SELECT, O_PRECISION_SELECT, O_EXC_MASK} ==
		{O_CONTROL_WORD[11:8], O_CONTROL_WORD[5:0]}) else $error("mode fields differ");
	a_trap_rule: assert property (I_CMD.valid |-> O_TRAP_REQ == (O_ERROR && !exempt))
		else $error("trap request wrong");
	a_refused_frozen: assert property (I_CMD.valid && O_TRAP_REQ |=> $stable(O_STATUS_WORD)
		&& $stable(O_CONTROL_WORD) && $stable(O_TAG_WORD)) else $error("refused command changed state");
	a_sticky_flags: assert property (s_take(fpu_status_pkg::OP_ARITH) |=> O_STATUS_WORD[6:0] ==
		($past(O_STATUS_WORD[6:0]) | {$past(I_CMD.stack_fault), $past(I_CMD.exc)}))
		else $error("flags not sticky");
	a_compare_code: assert property (s_take(fpu_status_pkg::OP_COMPARE) |=>
		{O_STATUS_WORD[14], O_STATUS_WORD[10], O_STATUS_WORD[8]} == cmp_map($past(I_CMD.cmp)))
		else $error("compare code wrong");
	a_prem_code: assert property (s_take(fpu_status_pkg::OP_PREM) |=>
		O_STATUS_WORD[10] == $past(I_CMD.incomplete) && ($past(I_CMD.incomplete) ||
		{O_STATUS_WORD[8], O_STATUS_WORD[14]} == $past(I_CMD.quotient[2:1])))
		else $error("remainder code wrong");
	a_init_values: assert property (s_take(fpu_status_pkg::OP_INIT) |=> O_CONTROL_WORD ==
		16'h037f && O_TAG_WORD == 16'hffff && O_STATUS_WORD[13:11] == 3'h0 &&
		O_STATUS_WORD[7:0] == 8'h00) else $error("initial values wrong");
	a_trig_keep: assert property (s_take(fpu_status_pkg::OP_TRIG) ##0 I_CMD.out_of_range
		|=> O_KEEP_OPERAND && O_STATUS_WORD[10]) else $error("out of range not kept");
	a_store_pulse: assert property (s_take(fpu_status_pkg::OP_STORE_ENV) |=> O_STORE_VALID)
		else $error("store image not flagged");
	a_top_push: assert property (s_take(fpu_status_pkg::OP_ARITH) ##0 I_CMD.push && !I_CMD.pop
		|=> O_STATUS_WORD[13:11] == $past(O_STATUS_WORD[13:11]) - 3'h1) else $error("push top wrong");
endmodule // fpu_status_assertions

bind fpu_status_control_exceptions fpu_status_assertions u_chk (.I_REF_CLK, .I_NRST, .I_CMD,
	.O_TRAP_REQ, .O_ERROR, .O_STATUS_WORD, .O_CONTROL_WORD, .O_TAG_WORD, .O_ROUNDING_SELECT,
	.O_PRECISION_SELECT, .O_EXC_MASK, .O_KEEP_OPERAND, .O_STORE_VALID);

/* File: testbench/tb.sv */
// Self-checking bench for the numeric status and control unit.
// Assumes the host model drives commands and the checker is bound to the unit.
`timescale 1ns/1ps
module tb;
	logic                 clk;
	logic                 nrst;
	logic                 trap;
	logic                 err;
	logic                 sv;
	logic                 keep;
	logic                 tr;
	logic [15:0]          sw;
	logic [15:0]          cw;
	logic [15:0]          tw;
	logic [5:0]           da;
	logic [5:0]           fu;
	logic [5:0]           m;
	logic [5:0]           x;
	logic [5:0]           u;
	logic [3:0]           cc;
	int                   failures;
	int                   checked;
	int                   seed;
	fpu_status_pkg::cmd_s cmd;
	fpu_status_pkg::cmd_s c;
	fpu_status_pkg::env_s img;
	fpu_status_pkg::env_s simg;
	fpu_status_pkg::env_s e;
	fpu_status_pkg::op_e  ex_ops [5] = '{fpu_status_pkg::OP_INIT, fpu_status_pkg::OP_CLEAR,
		fpu_status_pkg::OP_STORE_SW, fpu_status_pkg::OP_STORE_ENV, fpu_status_pkg::OP_SAVE};
	fpu_host_model host (.i_clk(clk), .i_trap(trap), .o_cmd(cmd), .o_image(img));
	fpu_status_control_exceptions dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_CMD(cmd),
		.I_LOAD_IMAGE(img), .O_TRAP_REQ(trap), .O_ERROR(err), .O_STATUS_WORD(sw),
		.O_CONTROL_WORD(cw), .O_TAG_WORD(tw), .O_ROUNDING_SELECT(), .O_PRECISION_SELECT(),
		.O_EXC_MASK(), .O_DEFAULT_ACTION(da), .O_FIRST_UNMASKED(fu), .O_KEEP_OPERAND(keep),
		.O_STORE_IMAGE(simg), .O_STORE_VALID(sv));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic close_out;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] got);
		checked++;
		if (got !== ex) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, ex, got);
		end
	endtask
	function automatic fpu_status_pkg::cmd_s mk(fpu_status_pkg::op_e op, logic nw);
		mk = '0;
		mk.valid = 1'b1;
		mk.op = op;
		mk.nowait = nw;
	endfunction
	function automatic logic [2:0] cmp_exp(logic [1:0] k);
		return (k == 2'h0) ? 3'h0 : (k == 2'h1) ? 3'h1 : (k == 2'h2) ? 3'h4 : 3'h7;
	endfunction
	task automatic go(input fpu_status_pkg::op_e op, input logic nw);
		c.op = op;
		c.nowait = nw;
		c.valid = 1'b1;
		host.issue(c, e, tr);
	endtask
	initial begin
		#900000;
		failures++;
		close_out();
	end
	initial begin
		seed = 32974;
		failures = 0;
		checked = 0;
		nrst = 1'b0;
		e = '0;
		c = '0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk("control", 16'h037f, cw);
		chk("tags", 16'hffff, tw);
		chk("status", 16'h0000, sw);
		for (int i = 0; i < 8; i++) begin
			e.control = 16'($random(seed)) & 16'h1f3f;
			go(fpu_status_pkg::OP_LOAD_CW, 1'b0);
			chk("control load", e.control, cw);
		end
		// The first pass is a hand-picked corner: every flag raised, two of them unmasked.
		for (int i = 0; i < 16; i++) begin
			m = (i == 0) ? 6'h3a : 6'($random(seed));
			x = (i == 0) ? 6'h3f : 6'($random(seed));
			u = x & ~m;
			c = '0;
			go(fpu_status_pkg::OP_INIT, 1'b1);
			e.control = 16'h0340 | 16'(m);
			go(fpu_status_pkg::OP_LOAD_CW, 1'b0);
			c.exc = x;
			go(fpu_status_pkg::OP_ARITH, 1'b0);
			chk("status", {|u, 7'h00, |u, 1'b0, x}, sw);
			chk("error", 16'(|u), 16'(err));
			chk("first unmasked", 16'(u & (~u + 6'h01)), 16'(fu));
			chk("default action", 16'(x & m), 16'(da));
			c.exc = 6'h00;
			go(fpu_status_pkg::OP_ARITH, 1'b0);
			chk("trap", 16'(|u), 16'(tr));
			chk("trap vector", (|u) ? 16'h0010 : 16'h0000, 16'(host.vector_taken));
			chk("sticky flags", 16'(x), 16'(sw[5:0]));
			go(ex_ops[i % 5], 1'b1);
			chk("no-wait trap", 16'h0000, 16'(tr));
		end
		for (int i = 0; i < 2; i++) begin
			c = '0;
			go(fpu_status_pkg::OP_INIT, 1'b1);
			c.exc = 6'h01;
			c.stack_fault = 1'b1;
			c.stack_over = i[0];
			go(fpu_status_pkg::OP_ARITH, 1'b0);
			chk("stack fault", 16'({i[0], 2'h3}), 16'({sw[9], sw[6], sw[0]}));
		end
		c = '0;
		for (int k = 0; k < 4; k++) begin
			c.cmp = fpu_status_pkg::cmp_e'(k);
			go(fpu_status_pkg::OP_COMPARE, 1'b0);
			chk("compare", 16'(cmp_exp(2'(k))), 16'({sw[14], sw[10], sw[8]}));
		end
		c.cmp = fpu_status_pkg::CMP_GREATER;
		for (int k = 0; k < 7; k++) begin
			c.cls = fpu_status_pkg::class_e'(k);
			c.sign = 1'($random(seed));
			go(fpu_status_pkg::OP_EXAMINE, 1'b0);
			chk("examine", 16'({3'(k), c.sign}), 16'({sw[14], sw[10], sw[8], sw[9]}));
		end
		for (int q = 0; q < 9; q++) begin
			c.incomplete = (q == 8);
			c.quotient = 3'(q);
			go(fpu_status_pkg::OP_PREM, 1'b0);
			chk("remainder", (q == 8) ? 16'h0008 : 16'(q), 16'({sw[10], sw[8], sw[14], sw[9]}));
		end
		c = '0;
		c.out_of_range = 1'b1;
		go(fpu_status_pkg::OP_TRIG, 1'b0);
		chk("trig range", 16'h0003, 16'({keep, sw[10]}));
		c = '0;
		go(fpu_status_pkg::OP_INIT, 1'b1);
		c.push = 1'b1;
		c.tag_we = 1'b1;
		c.tag_idx = 3'($random(seed));
		c.tag_code = 2'($random(seed)) & 2'h1;
		go(fpu_status_pkg::OP_ARITH, 1'b0);
		chk("top", 16'h0007, 16'(sw[13:11]));
		chk("tag", ~(16'h3 << (2 * c.tag_idx)) | (16'(c.tag_code) << (2 * c.tag_idx)), tw);
		cc = 4'($random(seed));
		e.control = 16'h037e;
		e.status = {1'b0, cc[3], 3'h5, cc[2:0], 2'h0, 6'h01};
		e.tags = 16'($random(seed));
		go(fpu_status_pkg::OP_LOAD_ENV, 1'b0);
		chk("loaded status", {1'b1, cc[3], 3'h5, cc[2:0], 2'h2, 6'h01}, sw);
		chk("loaded error", 16'h0001, 16'(err));
		chk("loaded control", e.control, cw);
		chk("loaded tags", e.tags, tw);
		go(fpu_status_pkg::OP_CLEAR, 1'b1);
		chk("cleared error", 16'h0000, 16'(err));
		c = '0;
		c.has_mem = 1'b1;
		c.ptr = 51'({$random(seed), $random(seed)});
		go(fpu_status_pkg::OP_ARITH, 1'b0);
		go(fpu_status_pkg::OP_STORE_ENV, 1'b1);
		chk("store valid", 16'h0001, 16'(sv));
		chk("store control", e.control, simg.control);
		chk("store tags", e.tags, simg.tags);
		chk("store pointers", 16'h0001, 16'(simg.ptr === c.ptr));
		// A reset in mid-run must bring back the start-up words from a dirty state.
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk("reset control", 16'h037f, cw);
		chk("reset tags", 16'hffff, tw);
		chk("reset status", 16'h0000, sw);
		close_out();
	end
endmodule // tb
